// *** hw/sibs_fifo.v ***
// Parameterised synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module sibs_fifo #(
  parameter WIDTH = 11,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire sys_clk_in,
  input wire rst_in,
  input wire ce_in,
  input wire in_valid_in,
  output wire in_ready_out,
  input wire [WIDTH-1:0] in_data_in,
  output wire out_valid_out,
  input wire out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wp_reg;
  reg [AW-1:0] rp_reg;
  reg [AW:0] cnt_reg;
  wire push;
  wire pop;
  assign in_ready_out = (cnt_reg != DEPTH[AW:0]);
  assign out_valid_out = (cnt_reg != {(AW+1){1'b0}});
  assign out_data_out = mem[rp_reg];
  assign push = ce_in & in_valid_in & in_ready_out;
  assign pop = ce_in & out_valid_out & out_ready_in;
  always @(posedge sys_clk_in) begin
    if (push) begin
      mem[wp_reg] <= in_data_in;
    end
  end
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      wp_reg <= {AW{1'b0}};
      rp_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_reg <= wp_reg + 1'b1;
      end
      if (pop) begin
        rp_reg <= rp_reg + 1'b1;
      end
      if (push & ~pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop & ~push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule

// *** hw/sibs_slave.v ***
// Management bus target with indexed block write and read into a byte space.
`timescale 1ns/1ps
`include "sibs_consts.vh"
module sibs_slave (
  input wire sys_clk_in,
  input wire rst_in,
  input wire ce_in,
  input wire [6:0] dev_addr_in,
  input wire ref_clk_in,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe_n_out,
  output reg [63:0] cfg_bytes_out,
  output reg [10:0] wr_data_out,
  output reg wr_valid_out,
  input wire wr_ready_in,
  output reg busy_out,
  output reg ref_alive_out
);
  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_INDEX = 3'd2;
  localparam ST_COUNT = 3'd3;
  localparam ST_WDATA = 3'd4;
  localparam ST_RDATA = 3'd5;
  localparam ST_SKIP = 3'd6;
  localparam PH_BIT = 2'd0;
  localparam PH_ACK = 2'd1;
  localparam PH_MACK = 2'd2;

  reg [2:0] scl_sync_reg;
  reg [2:0] sda_sync_reg;
  reg [2:0] ref_sync_reg;
  reg [7:0] cfg_mem [0:`SIBS_CFG_BYTES-1];
  reg [2:0] state_reg;
  reg [1:0] phase_reg;
  reg [3:0] bit_reg;
  reg [7:0] shift_reg;
  reg [2:0] index_reg;
  reg rd_dir_reg;
  reg drive_low_reg;
  reg [7:0] tx_reg;
  reg [15:0] ref_cnt_reg;
  wire scl_s;
  wire sda_s;
  wire scl_rise;
  wire scl_fall;
  wire start_cond;
  wire stop_cond;
  wire fifo_out_valid;
  wire [10:0] fifo_out_data;
  wire fifo_in_ready;
  reg fifo_push;
  reg [10:0] fifo_push_data;
  wire fifo_pop;
  wire [7:0] rx_byte;
  integer i;
  integer j;

  assign scl_s = scl_sync_reg[1];
  assign sda_s = sda_sync_reg[1];
  assign scl_rise = scl_sync_reg[1] & ~scl_sync_reg[2];
  assign scl_fall = ~scl_sync_reg[1] & scl_sync_reg[2];
  assign start_cond = scl_s & scl_sync_reg[2] & ~sda_sync_reg[1] & sda_sync_reg[2];
  assign stop_cond = scl_s & scl_sync_reg[2] & sda_sync_reg[1] & ~sda_sync_reg[2];
  assign rx_byte = {shift_reg[6:0], sda_s};
  // Written bytes drain into configuration storage one at a time, each once the store port has taken the previous one.
  assign fifo_pop = fifo_out_valid & ~wr_valid_out;

  // Two flip-flops before anything reads the pins; the third stage only delays.
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      ref_sync_reg <= 3'h0;
    end else if (ce_in) begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
      ref_sync_reg <= {ref_sync_reg[1:0], ref_clk_in};
    end
  end

  // A stalled reference clock makes the port ignore the bus.
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      ref_cnt_reg <= 16'h0000;
      ref_alive_out <= 1'b0;
    end else if (ce_in) begin
      if (ref_sync_reg[1] != ref_sync_reg[2]) begin
        ref_cnt_reg <= 16'h0000;
        ref_alive_out <= 1'b1;
      end else if (ref_cnt_reg >= `SIBS_REF_TIMEOUT_CYC) begin
        ref_alive_out <= 1'b0;
      end else begin
        ref_cnt_reg <= ref_cnt_reg + 16'h0001;
      end
    end
  end

  always @* begin
    fifo_push = 1'b0;
    fifo_push_data = {index_reg, rx_byte};
    if (state_reg == ST_WDATA && phase_reg == PH_BIT && scl_rise && bit_reg == 4'h7) begin
      fifo_push = 1'b1;
    end
  end

  sibs_fifo #(
    .WIDTH(11),
    .DEPTH(`SIBS_FIFO_DEPTH),
    .AW(`SIBS_FIFO_AW)
  ) u_fifo (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .in_valid_in(fifo_push),
    .in_ready_out(fifo_in_ready),
    .in_data_in(fifo_push_data),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(~wr_valid_out),
    .out_data_out(fifo_out_data)
  );

  // Configuration store; index 6 holds the read count.
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      for (i = 0; i < `SIBS_CFG_BYTES; i = i + 1) begin
        cfg_mem[i] <= 8'h00;
      end
      cfg_mem[`SIBS_COUNT_IDX] <= `SIBS_COUNT_RESET;
      wr_valid_out <= 1'b0;
      wr_data_out <= 11'h000;
    end else if (ce_in) begin
      if (wr_valid_out & wr_ready_in) begin
        wr_valid_out <= 1'b0;
      end
      if (fifo_pop) begin
        cfg_mem[fifo_out_data[10:8]] <= fifo_out_data[7:0];
        wr_data_out <= fifo_out_data;
        wr_valid_out <= 1'b1;
      end
    end
  end

  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      // The image shows the reset contents at once, so no change appears after reset.
      cfg_bytes_out <= {8'h00, `SIBS_COUNT_RESET, 48'h0};
    end else if (ce_in) begin
      for (j = 0; j < `SIBS_CFG_BYTES; j = j + 1) begin
        cfg_bytes_out[j*8 +: 8] <= cfg_mem[j];
      end
    end
  end

  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      state_reg <= ST_IDLE;
      phase_reg <= PH_BIT;
      bit_reg <= 4'h0;
      shift_reg <= 8'h00;
      index_reg <= 3'h0;
      rd_dir_reg <= 1'b0;
      drive_low_reg <= 1'b0;
      tx_reg <= 8'h00;
      sda_out <= 1'b0;
      sda_oe_n_out <= 1'b1;
      busy_out <= 1'b0;
    end else if (ce_in) begin
      sda_out <= 1'b0;
      sda_oe_n_out <= ~drive_low_reg;
      busy_out <= (state_reg != ST_IDLE);
      if (!ref_alive_out || stop_cond) begin
        state_reg <= ST_IDLE;
        drive_low_reg <= 1'b0;
      end else if (start_cond) begin
        state_reg <= ST_ADDR;
        phase_reg <= PH_BIT;
        bit_reg <= 4'h0;
        drive_low_reg <= 1'b0;
      end else if (state_reg != ST_IDLE && state_reg != ST_SKIP) begin
        case (phase_reg)
          PH_BIT: begin
            if (scl_rise && state_reg != ST_RDATA) begin
              shift_reg <= rx_byte;
              bit_reg <= bit_reg + 4'h1;
              if (bit_reg == 4'h7) begin
                phase_reg <= PH_ACK;
                case (state_reg)
                  ST_ADDR: begin
                    if (rx_byte[7:1] == dev_addr_in) begin
                      rd_dir_reg <= rx_byte[0];
                    end else begin
                      state_reg <= ST_SKIP;
                    end
                  end
                  ST_INDEX: index_reg <= rx_byte[2:0];
                  ST_WDATA: begin
                    index_reg <= index_reg + 3'h1;
                    if (!fifo_in_ready) begin
                      state_reg <= ST_SKIP;
                    end
                  end
                  default: state_reg <= state_reg;
                endcase
              end
            end else if (scl_fall && state_reg == ST_RDATA) begin
              drive_low_reg <= ~tx_reg[7];
              tx_reg <= {tx_reg[6:0], 1'b0};
              bit_reg <= bit_reg + 4'h1;
              if (bit_reg == 4'h8) begin
                drive_low_reg <= 1'b0;
                phase_reg <= PH_MACK;
              end
            end
          end
          PH_ACK: begin
            if (scl_fall) begin
              // The ack bit is held low from this fall to the next one.
              if (drive_low_reg) begin
                drive_low_reg <= 1'b0;
                bit_reg <= 4'h0;
                phase_reg <= PH_BIT;
                case (state_reg)
                  ST_ADDR: begin
                    if (rd_dir_reg) begin
                      state_reg <= ST_RDATA;
                      bit_reg <= 4'h1;
                      drive_low_reg <= ~cfg_mem[`SIBS_COUNT_IDX][7];
                      tx_reg <= {cfg_mem[`SIBS_COUNT_IDX][6:0], 1'b0};
                    end else begin
                      state_reg <= ST_INDEX;
                    end
                  end
                  ST_INDEX: state_reg <= ST_COUNT;
                  ST_COUNT: state_reg <= ST_WDATA;
                  default: state_reg <= state_reg;
                endcase
              end else begin
                drive_low_reg <= 1'b1;
              end
            end
          end
          PH_MACK: begin
            // The next byte is loaded only at the fall that ends the host's acknowledge;
            // leaving this phase at the rise would lose that fall and send nothing.
            if (scl_rise && sda_s) begin
              state_reg <= ST_SKIP;
            end else if (scl_fall) begin
              phase_reg <= PH_BIT;
              drive_low_reg <= ~cfg_mem[index_reg][7];
              tx_reg <= {cfg_mem[index_reg][6:0], 1'b0};
              index_reg <= index_reg + 3'h1;
              bit_reg <= 4'h1;
            end
          end
          default: phase_reg <= PH_BIT;
        endcase
      end
    end
  end
endmodule

// *** include/sibs_consts.vh ***
// Constants for the indexed block slave of the management bus.
// Notes on behaviour
// - After the address the host sends a start index byte, which the device acknowledges.
// - In a block write a byte count follows the index and the device acknowledges it.
// - Data bytes go to consecutive indices from the start index and each is acknowledged while the buffer has room.
// - The device acknowledges the read-direction address and sends the byte count first.
// - After the count the device sends configuration bytes in ascending index order.
// - The byte at index 6 is sent first and does not limit a block read; the device keeps sending until the host does not acknowledge.
// - The port answers only while the reference clock input is toggling.
`ifndef SIBS_CONSTS_VH
`define SIBS_CONSTS_VH
`define SIBS_ADDR_W 7
`define SIBS_ADDR_DEFAULT 7'h6E
`define SIBS_CFG_BYTES 8
`define SIBS_IDX_W 3
`define SIBS_COUNT_IDX 3'h6
`define SIBS_COUNT_RESET 8'h07
`define SIBS_FIFO_DEPTH 16
`define SIBS_FIFO_AW 4
`define SIBS_REF_TIMEOUT_NS 1000
`define SIBS_CLK_NS 10
`define SIBS_REF_TIMEOUT_CYC ((`SIBS_REF_TIMEOUT_NS) / (`SIBS_CLK_NS))
`define SIBS_BUS_MAX_KHZ 440
`endif

// *** verification/sibs_host.sv ***
// Host model that drives the two-wire management bus.
`timescale 1ns/1ps
module sibs_host (
  input wire logic sys_clk_in,
  input wire logic sda_in,
  output logic scl_out = 1'b1,
  output logic sda_out = 1'b1
);
  // A quarter bit of 60 cycles gives about 417 kHz, under the bus ceiling.
  localparam int H = 60;
  task automatic drive(input logic c, input logic d);
    repeat (H) @(posedge sys_clk_in);
    scl_out <= c;
    sda_out <= d;
  endtask
  task automatic bit_io(input logic b, output logic s);
    drive(1'b0, b);
    drive(1'b1, b);
    repeat (H) @(posedge sys_clk_in);
    s = sda_in;
    drive(1'b0, b);
  endtask
  task automatic start;
    drive(scl_out, 1'b1);
    drive(1'b1, 1'b1);
    drive(1'b1, 1'b0);
    drive(1'b0, 1'b0);
  endtask
  task automatic stop;
    drive(1'b0, 1'b0);
    drive(1'b1, 1'b0);
    drive(1'b1, 1'b1);
  endtask
  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask
  task automatic recv(input logic more, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(!more, s);
  endtask
endmodule

// *** verification/sibs_slave_props.sv ***
// Port checks for the management bus target.
`timescale 1ns/1ps
module sibs_slave_props (
  input logic sys_clk_in,
  input logic rst_in,
  input logic scl_in,
  input logic sda_out,
  input logic sda_oe_n_out,
  input logic [63:0] cfg_bytes_out,
  input logic [10:0] wr_data_out,
  input logic wr_valid_out,
  input logic wr_ready_in,
  input logic busy_out,
  input logic ref_alive_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);
  a_reset_state: assert property (disable iff (1'b0) rst_in |=> sda_oe_n_out
    && !busy_out && cfg_bytes_out == 64'h0007000000000000) else $error("bad reset state");
  a_open_drain: assert property (!sda_oe_n_out |-> !sda_out)
    else $error("data driven high");
  a_pull_stands: assert property ($fell(sda_oe_n_out) |=> !sda_oe_n_out [*8])
    else $error("data pull too short");
  a_edge_scl_low: assert property ($changed(sda_oe_n_out) |-> !scl_in)
    else $error("data moved while clock high");
  a_store_hold: assert property (wr_valid_out && !wr_ready_in |=>
    wr_valid_out && $stable(wr_data_out)) else $error("store dropped");
  a_cfg_stored: assert property ($changed(cfg_bytes_out) |-> $past(wr_valid_out))
    else $error("config changed without store");
  a_dead_silent: assert property (!ref_alive_out |-> sda_oe_n_out)
    else $error("answer without reference clock");
  a_start_busy: assert property ($rose(busy_out) |-> scl_in)
    else $error("busy without start");
endmodule

// *** verification/tb_sibs_slave.sv ***
// Self-checking bench for the indexed block target.
`timescale 1ns/1ps
`include "sibs_consts.vh"
module tb_sibs_slave;
  localparam logic [6:0] DEV = `SIBS_ADDR_DEFAULT;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic ref_clk = 1'b0;
  logic ref_run = 1'b1;
  logic stall = 1'b0;
  logic wr_ready = 1'b0;
  logic [1:0] phase = 2'h0;
  wire scl, host_sda, sda_drv, oe_n, wr_valid, busy, alive;
  wire sda_bus = host_sda & (oe_n | sda_drv);
  wire [63:0] cfg;
  wire [10:0] wr_data;
  int fails = 0;
  int checks_done = 0;
  logic [7:0] model [8];
  logic [10:0] exp_q [$];
  always #5 sys_clk_in = ~sys_clk_in;
  initial #3 forever #80 ref_clk = ref_run ? ~ref_clk : ref_clk;
  sibs_host sibs_host_i (.sys_clk_in(sys_clk_in), .sda_in(sda_bus), .scl_out(scl),
    .sda_out(host_sda));
  sibs_slave sibs_slave_i (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .ce_in(1'b1),
    .dev_addr_in(DEV), .ref_clk_in(ref_clk), .scl_in(scl), .sda_in(sda_bus),
    .sda_out(sda_drv), .sda_oe_n_out(oe_n), .cfg_bytes_out(cfg), .wr_data_out(wr_data),
    .wr_valid_out(wr_valid), .wr_ready_in(wr_ready), .busy_out(busy), .ref_alive_out(alive));
  task automatic cmp(input string what, input logic [63:0] exp, input logic [63:0] seen);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic conclude;
    if (fails == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // The store side takes one cycle in four, or none while the buffer is being filled.
  always @(posedge sys_clk_in) begin
    phase <= phase + 2'h1;
    wr_ready <= !stall && phase == 2'h0;
    if (wr_valid && wr_ready) cmp("store", exp_q.pop_front(), wr_data);
  end
  task automatic tx(input logic [7:0] b, input logic want);
    logic ack;
    sibs_host_i.send(b, ack);
    cmp("ack", want, ack);
  endtask
  task automatic wdata(input int idx, output logic ack);
    logic [7:0] b;
    b = 8'($urandom);
    // The store port hands the byte out before its acknowledge bit is clocked.
    exp_q.push_back({3'(idx % 8), b});
    sibs_host_i.send(b, ack);
    if (ack) begin
      model[idx % 8] = b;
    end else begin
      void'(exp_q.pop_back());
    end
  endtask
  task automatic rx(input int idx, input logic more);
    logic [7:0] b;
    sibs_host_i.recv(more, b);
    cmp("read", model[idx], b);
  endtask
  task automatic settle;
    int n;
    for (n = 0; n < 2000 && (busy !== 1'b0 || exp_q.size() > 0); n++) @(posedge sys_clk_in);
    if (n == 2000) begin
      fails++;
      conclude();
    end
    repeat (2) @(posedge sys_clk_in);
    for (int k = 0; k < 8; k++) cmp("cfg", model[k], cfg[8*k +: 8]);
  endtask
  initial begin
    logic ack;
    int k;
    void'($urandom(47));
    for (k = 0; k < 8; k++) model[k] = 8'h00;
    model[6] = 8'h07;
    repeat (4) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    settle();
    sibs_host_i.start();
    tx({DEV, 1'b0}, 1'b1);
    tx(8'h05, 1'b1);
    tx(8'h04, 1'b1);
    for (k = 5; k < 9; k++) begin
      wdata(k, ack);
      cmp("ack", 1'b1, ack);
    end
    sibs_host_i.stop();
    settle();
    sibs_host_i.start();
    tx({DEV, 1'b0}, 1'b1);
    tx(8'h07, 1'b1);
    sibs_host_i.start();
    tx({DEV, 1'b1}, 1'b1);
    rx(6, 1'b1);
    for (k = 7; k < 10; k++) rx(k % 8, k < 9);
    sibs_host_i.stop();
    sibs_host_i.start();
    tx({DEV ^ 7'h01, 1'b0}, 1'b0);
    sibs_host_i.stop();
    stall <= 1'b1;
    sibs_host_i.start();
    tx({DEV, 1'b0}, 1'b1);
    tx(8'h00, 1'b1);
    tx(8'h14, 1'b1);
    ack = 1'b1;
    for (k = 0; k < 20 && ack; k++) wdata(k, ack);
    // One byte waits at the stalled store port and the buffer holds the rest.
    cmp("fill", `SIBS_FIFO_DEPTH + 2, k);
    sibs_host_i.stop();
    stall <= 1'b0;
    settle();
    ref_run = 1'b0;
    repeat (300) @(posedge sys_clk_in);
    cmp("alive", 1'b0, alive);
    sibs_host_i.start();
    tx({DEV, 1'b0}, 1'b0);
    sibs_host_i.stop();
    ref_run = 1'b1;
    repeat (50) @(posedge sys_clk_in);
    cmp("alive", 1'b1, alive);
    conclude();
  end
endmodule
bind sibs_slave sibs_slave_props sibs_slave_props_i (.sys_clk_in(sys_clk_in),
  .rst_in(rst_in), .scl_in(scl_in), .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out),
  .cfg_bytes_out(cfg_bytes_out), .wr_data_out(wr_data_out), .wr_valid_out(wr_valid_out),
  .wr_ready_in(wr_ready_in), .busy_out(busy_out), .ref_alive_out(ref_alive_out));
